// >>> hw/rmc_config_bank.sv
// Purpose: modem and packet engine configuration registers with rx timeout and recal
// Assumes: pclk 25 MHz stands for the crystal clock; gpio inputs asynchronous
// Notes: single apb slave, zero wait states
//
// Summary of operation
// - writing one to calibration bit starts i/q calibration; bit clears when done
// - writing zero aborts calibration; runs regardless of correction enable
// - correction enable bit drives i/q correction on or off
// - two-bit field sets rssi decay rate per symbol multiple
// - four-bit field selects channel filter width, 600 kHz down to 9 kHz
// - bit order control: msb first at 0, lsb first at 1
// - inversion bit inverts every sent and received data bit
// - manchester and whitening enabled independently
// - preamble enable controls preamble transmission
// - packet enable switches tx and rx to packet operation
// - crc enable appends and checks crc
// - address enable inserts and compares address byte
// - modulation bit: ook at 0, fsk at 1
// - gaussian bit enables tx shaping and rx matched filter
// - interpolator bit routes tx modulator through interpolator
// - mixer sign bit picks positive or negative if
// - injection bit picks high or low side injection
// - direct modulation source: none, zero, one, or gpio 0..3
// - carrier sense compares signal strength to four-bit threshold
// - rx timeout in clocks from exponent and mantissa formula
// - after timeout, postponement follows the two-bit condition
// - recalibration ratio: always, 1:4 to 1:128, never
// - timeout action: error state or flush, recalibrate, resume
`timescale 1ns/10ps
`default_nettype none
module rmc_config_bank
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] gpio_in,
    input wire logic [3:0] rssi_level,
    input wire logic rx_active,
    input wire logic payload_active,
    input wire logic restart_pulse,
    input wire logic iq_cal_done,
    output rmc_pkg::rmc_coding_t coding,
    output rmc_pkg::rmc_mod_t modulation,
    output logic carrier_sense,
    output logic iq_cal_busy,
    output logic rx_term_error,
    output logic rx_term_restart,
    output logic recal_request
);
    import rmc_pkg::*;

    // ****************************************
    // apb decode
    // ****************************************
    logic [7:0] iq_reg, coding_reg, mod_reg, cs_reg, term_reg, cal_reg, act_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    wire access = psel && penable;
    wire [5:0] idx = paddr[7:2];
    wire wr = access && pwrite && pstrb[0];
    wire hit_iq = (idx == IDX_IQ_RSSI_BW);
    wire hit_cod = (idx == IDX_BIT_CODING);
    wire hit_mod = (idx == IDX_MODULATION);
    wire hit_cs = (idx == IDX_CS_THRESH);
    wire hit_int = (idx == IDX_RX_TERM_INT);
    wire hit_cal = (idx == IDX_RX_TERM_CAL);
    wire hit_act = (idx == IDX_RX_TERM_ACT);
    wire hit_st = (idx == IDX_STATUS);
    wire mapped = hit_iq || hit_cod || hit_mod || hit_cs || hit_int || hit_cal || hit_act || hit_st;
    wire [7:0] wb = pwdata[7:0];
    logic [7:0] status_byte;
    logic [7:0] rd_byte;

    always_comb
    begin
        if (hit_iq) rd_byte = iq_reg;
        else if (hit_cod) rd_byte = coding_reg;
        else if (hit_mod) rd_byte = mod_reg;
        else if (hit_cs) rd_byte = cs_reg;
        else if (hit_int) rd_byte = term_reg;
        else if (hit_cal) rd_byte = cal_reg;
        else if (hit_act) rd_byte = act_reg;
        else if (hit_st) rd_byte = status_byte;
        else rd_byte = RST_BYTE;
    end

    // latched in setup so data and error stand with pready in the access cycle
    wire setup_phase = psel && !penable;
    assign prdata_next = (setup_phase && !pwrite) ? {24'h00_0000, rd_byte} : prdata_reg;
    // unmapped accesses answer with pslverr, reads give zero
    assign pslverr_next = setup_phase && !mapped;

    // ****************************************
    // plain config registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            coding_reg <= RST_BYTE;
            mod_reg <= RST_BYTE;
            cs_reg <= RST_BYTE;
            term_reg <= RST_BYTE;
            cal_reg <= RST_BYTE;
            act_reg <= RST_BYTE;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            pready <= 1'b0;
        end
        else
        begin
            if (wr && hit_cod) coding_reg <= wb;
            if (wr && hit_mod) mod_reg <= wb;
            if (wr && hit_cs) cs_reg <= wb & MASK_CS;
            if (wr && hit_int) term_reg <= wb;
            if (wr && hit_cal) cal_reg <= wb & MASK_CAL;
            if (wr && hit_act) act_reg <= wb & MASK_ACT;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready <= setup_phase;
        end
    end
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // ****************************************
    // i/q calibration, self-clearing
    // ****************************************
    logic [10:0] iq_cnt_reg;
    wire iq_wr = wr && hit_iq;
    wire iq_finish = iq_reg[BIT_IQ_CAL] && ((iq_cnt_reg == IQ_CAL_LAST) || iq_cal_done);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            iq_reg <= RST_BYTE;
            iq_cnt_reg <= 11'h000;
        end
        else
        begin
            if (iq_wr)
            begin
                iq_reg <= wb;
                iq_cnt_reg <= 11'h000;
            end
            else if (iq_finish)
            begin
                iq_reg[BIT_IQ_CAL] <= 1'b0;
                iq_cnt_reg <= 11'h000;
            end
            else if (iq_reg[BIT_IQ_CAL])
                iq_cnt_reg <= iq_cnt_reg + 11'h001;
        end
    end

    // ****************************************
    // gpio synchronisers and direct modulation
    // ****************************************
    logic [3:0] gpio_s1_reg, gpio_s2_reg;
    wire [2:0] dm_src = mod_reg[2:0];
    wire dm_active = dm_src[2] || dm_src[1];
    wire dm_level = dm_src[2] ? gpio_s2_reg[dm_src[1:0]] : dm_src[0];

    // ****************************************
    // rx termination timeout
    // ****************************************
    function automatic logic [31:0] term_cycles(input logic [3:0] e, input logic [3:0] m);
        logic [31:0] base;
        base = 32'h0000_0000;
        if (e == 4'h0)
            base = TERM_UNIT * (32'(m) + 32'h0000_0001);
        else
            base = (TERM_UNIT * (32'(m) + 32'(TERM_MANT_OFS))) << (e - 4'h1);
        return base;
    endfunction : term_cycles

    rmc_term_state_t term_state_reg, term_state_next;
    logic [31:0] term_cnt_reg;
    logic rx_s1_reg, rx_s2_reg, pay_s1_reg, pay_s2_reg, rst_s1_reg, rst_s2_reg, rst_s3_reg;
    logic [3:0] rssi_s1_reg, rssi_s2_reg;
    wire [31:0] term_limit = term_cycles(term_reg[7:4], term_reg[3:0]);
    wire [1:0] cond = cal_reg[7:6];
    wire above_th = rssi_s2_reg > cs_reg[3:0];
    logic postpone;
    always_comb
    begin
        case (cond)
            2'b00: postpone = 1'b1;
            2'b01: postpone = 1'b0;
            2'b10: postpone = above_th || pay_s2_reg;
            default: postpone = pay_s2_reg;
        endcase
    end
    wire expire_now = (term_cnt_reg >= term_limit - 32'h0000_0001);
    wire fire = (term_state_reg == TERM_LATE) && !postpone && rx_s2_reg;

    always_comb
    begin
        term_state_next = term_state_reg;
        case (term_state_reg)
            TERM_IDLE: if (rx_s2_reg) term_state_next = TERM_RUN;
            TERM_RUN:
            begin
                if (!rx_s2_reg) term_state_next = TERM_IDLE;
                else if (expire_now) term_state_next = TERM_LATE;
            end
            TERM_LATE: if (!rx_s2_reg || fire) term_state_next = TERM_IDLE;
            default: term_state_next = TERM_IDLE;
        endcase
    end

    // ****************************************
    // periodic recalibration counter
    // ****************************************
    logic [6:0] recal_cnt_reg;
    wire [3:0] ratio = {1'b0, cal_reg[2:0]};
    wire [7:0] period = 8'h01 << (ratio + RECAL_SHIFT);
    wire restart_evt = rst_s2_reg && !rst_s3_reg;
    wire at_end = ({1'b0, recal_cnt_reg} == period - 8'h01);
    wire recal_now = restart_evt && (ratio != RECAL_NEVER) && ((ratio == 4'h0) || at_end);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gpio_s1_reg <= 4'h0;
            gpio_s2_reg <= 4'h0;
            rssi_s1_reg <= 4'h0;
            rssi_s2_reg <= 4'h0;
            rx_s1_reg <= 1'b0;
            rx_s2_reg <= 1'b0;
            pay_s1_reg <= 1'b0;
            pay_s2_reg <= 1'b0;
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
            rst_s3_reg <= 1'b0;
            term_state_reg <= TERM_IDLE;
            term_cnt_reg <= 32'h0000_0000;
            recal_cnt_reg <= 7'h00;
            coding <= '0;
            modulation <= '0;
            carrier_sense <= 1'b0;
            iq_cal_busy <= 1'b0;
            rx_term_error <= 1'b0;
            rx_term_restart <= 1'b0;
            recal_request <= 1'b0;
        end
        else
        begin
            gpio_s1_reg <= gpio_in;
            gpio_s2_reg <= gpio_s1_reg;
            rssi_s1_reg <= rssi_level;
            rssi_s2_reg <= rssi_s1_reg;
            rx_s1_reg <= rx_active;
            rx_s2_reg <= rx_s1_reg;
            pay_s1_reg <= payload_active;
            pay_s2_reg <= pay_s1_reg;
            rst_s1_reg <= restart_pulse;
            rst_s2_reg <= rst_s1_reg;
            rst_s3_reg <= rst_s2_reg;
            term_state_reg <= term_state_next;
            term_cnt_reg <= (term_state_reg == TERM_RUN) ? term_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
            if (restart_evt)
                recal_cnt_reg <= (recal_now || ratio == 4'h0) ? 7'h00 : recal_cnt_reg + 7'h01;
            coding <= '{iq_correction_enable: iq_reg[7],
                        signal_strength_decay: iq_reg[5:4],
                        channel_filter_width: iq_reg[3:0],
                        lsb_first: coding_reg[7],
                        bit_invert: coding_reg[6],
                        manchester_on: coding_reg[5],
                        whitening_on: coding_reg[4],
                        preamble_on: coding_reg[3],
                        packet_on: coding_reg[2],
                        crc_on: coding_reg[1],
                        address_on: coding_reg[0]};
            modulation <= '{modulation_type_select: mod_reg[7],
                            gaussian_on: mod_reg[6],
                            tx_interpolator_on: mod_reg[5],
                            mixer_if_sign: mod_reg[4],
                            injection_side: mod_reg[3],
                            source_a_active: dm_active,
                            source_a_level: dm_level};
            carrier_sense <= above_th;
            iq_cal_busy <= iq_reg[BIT_IQ_CAL] && !iq_finish;
            rx_term_error <= fire && !act_reg[7];
            rx_term_restart <= fire && act_reg[7];
            recal_request <= recal_now || (fire && act_reg[7]);
        end
    end

    assign status_byte = {4'h0, term_state_reg == TERM_LATE, term_state_reg == TERM_RUN, carrier_sense, iq_cal_busy};

    // ****************************************
    // assertions
    // ****************************************
    property p_iq_clear;
        @(posedge pclk) disable iff (!presetn)
        iq_finish && !iq_wr |=> !iq_reg[BIT_IQ_CAL];
    endproperty
    a_iq_clear: assert property (p_iq_clear) else $error("cal bit not cleared");
    property p_iq_abort;
        @(posedge pclk) disable iff (!presetn)
        iq_wr && !wb[BIT_IQ_CAL] |=> !iq_reg[BIT_IQ_CAL] ##1 !iq_cal_busy;
    endproperty
    a_iq_abort: assert property (p_iq_abort) else $error("abort failed");
    property p_corr;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> coding.iq_correction_enable == $past(iq_reg[7]);
    endproperty
    a_corr: assert property (p_corr) else $error("correction enable mismatch");
    property p_cs;
        @(posedge pclk) disable iff (!presetn)
        rssi_s2_reg > cs_reg[3:0] |=> carrier_sense;
    endproperty
    a_cs: assert property (p_cs) else $error("carrier sense missing");
    property p_term_fire;
        @(posedge pclk) disable iff (!presetn)
        fire && !act_reg[7] |=> rx_term_error && !rx_term_restart;
    endproperty
    a_term_fire: assert property (p_term_fire) else $error("timeout action wrong");
    property p_postpone_forever;
        @(posedge pclk) disable iff (!presetn)
        cond == 2'b00 |-> !fire;
    endproperty
    a_postpone_forever: assert property (p_postpone_forever) else $error("terminated under forever");
    property p_never;
        @(posedge pclk) disable iff (!presetn)
        ratio == RECAL_NEVER |-> !recal_now;
    endproperty
    a_never: assert property (p_never) else $error("recal in never mode");
    property p_dm_zero;
        @(posedge pclk) disable iff (!presetn)
        dm_src == 3'h2 && $stable(mod_reg) |=> modulation.source_a_active && !modulation.source_a_level;
    endproperty
    a_dm_zero: assert property (p_dm_zero) else $error("source_a zero wrong");
    property p_count_len;
        @(posedge pclk) disable iff (!presetn)
        term_state_reg == TERM_RUN |-> term_cnt_reg < term_limit;
    endproperty
    a_count_len: assert property (p_count_len) else $error("timeout overran");
    property p_cal_busy;
        @(posedge pclk) disable iff (!presetn)
        iq_reg[BIT_IQ_CAL] && !iq_finish |=> iq_cal_busy;
    endproperty
    a_cal_busy: assert property (p_cal_busy) else $error("cal busy missing");
    property p_dm_none;
        @(posedge pclk) disable iff (!presetn)
        dm_src[2:1] == 2'b00 |=> !modulation.source_a_active;
    endproperty
    a_dm_none: assert property (p_dm_none) else $error("source_a active in none");
    property p_recal_always;
        @(posedge pclk) disable iff (!presetn)
        restart_evt && ratio == 4'h0 |=> recal_request;
    endproperty
    a_recal_always: assert property (p_recal_always) else $error("recal missing in always mode");
    property p_term_restart;
        @(posedge pclk) disable iff (!presetn)
        fire && act_reg[7] |=> rx_term_restart && recal_request && !rx_term_error;
    endproperty
    a_term_restart: assert property (p_term_restart) else $error("timeout restart wrong");
    c_cal: cover property (@(posedge pclk) disable iff (!presetn) iq_finish);
    c_fire: cover property (@(posedge pclk) disable iff (!presetn) fire);
    c_recal: cover property (@(posedge pclk) disable iff (!presetn) recal_now && ratio != 4'h0);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn) iq_wr && !wb[BIT_IQ_CAL] && iq_reg[BIT_IQ_CAL]);
    c_gpio_mod: cover property (@(posedge pclk) disable iff (!presetn) dm_src[2] && modulation.source_a_level);
endmodule : rmc_config_bank
`default_nettype wire

// >>> hw/rmc_pkg.sv
// Purpose: constants and carriers for the modem configuration register bank
// Assumes: apb with 32-bit data, registers in the low byte of each word
// Notes: printed offsets are not all multiples of four, so they are indices
package rmc_pkg;
    localparam int unsigned ADDR_W = 8;
    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [5:0] IDX_IQ_RSSI_BW = 6'h25;
    localparam logic [5:0] IDX_BIT_CODING = 6'h26;
    localparam logic [5:0] IDX_MODULATION = 6'h27;
    localparam logic [5:0] IDX_CS_THRESH = 6'h28;
    localparam logic [5:0] IDX_RX_TERM_INT = 6'h29;
    localparam logic [5:0] IDX_RX_TERM_CAL = 6'h2a;
    localparam logic [5:0] IDX_RX_TERM_ACT = 6'h2c;
    localparam logic [5:0] IDX_STATUS = 6'h30;
    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] MASK_CS = 8'h0f;
    localparam logic [7:0] MASK_CAL = 8'hc7;
    localparam logic [7:0] MASK_ACT = 8'h80;
    localparam int unsigned BIT_IQ_EN = 7;
    localparam int unsigned BIT_IQ_CAL = 6;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned IQ_CAL_US = 40;
    localparam int unsigned IQ_CAL_CYC = IQ_CAL_US * CLK_MHZ;
    localparam logic [10:0] IQ_CAL_LAST = 11'(IQ_CAL_CYC - 1);
    localparam logic [31:0] TERM_UNIT = 32'h0000_0800;
    localparam logic [4:0] TERM_MANT_OFS = 5'h11;
    localparam logic [3:0] RECAL_NEVER = 4'h7;
    localparam logic [3:0] RECAL_SHIFT = 4'h1;

    typedef struct packed {
        logic iq_correction_enable;
        logic [1:0] signal_strength_decay;
        logic [3:0] channel_filter_width;
        logic lsb_first;
        logic bit_invert;
        logic manchester_on;
        logic whitening_on;
        logic preamble_on;
        logic packet_on;
        logic crc_on;
        logic address_on;
    } rmc_coding_t;

    typedef struct packed {
        logic modulation_type_select;
        logic gaussian_on;
        logic tx_interpolator_on;
        logic mixer_if_sign;
        logic injection_side;
        logic source_a_active;
        logic source_a_level;
    } rmc_mod_t;

    typedef enum logic [2:0] {
        TERM_IDLE = 3'b001,
        TERM_RUN = 3'b010,
        TERM_LATE = 3'b100
    } rmc_term_state_t;
endpackage : rmc_pkg

// >>> tb/rmc_config_bank_bench.sv
// Purpose: self-checking bench for the modem configuration register bank
// Assumes: zero wait state apb slave, pclk stands for the crystal clock
// Notes: apb results go through a note queue; other outputs are checked in line
`timescale 1ns/10ps
`default_nettype none
module rmc_config_bank_bench;
    import rmc_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] gpio_in = '0;
    logic [3:0] rssi_level = '0;
    logic rx_active = 1'b0;
    logic payload_active = 1'b0;
    logic restart_pulse = 1'b0;
    logic iq_cal_done = 1'b0;
    rmc_coding_t coding;
    rmc_mod_t modulation;
    logic carrier_sense, iq_cal_busy, rx_term_error, rx_term_restart, recal_request;
    int fails = 0;
    int tests_run = 0;
    int err_cnt = 0;
    int rst_cnt = 0;
    int recal_cnt = 0;
    integer seed = 32'h4ec273ac;
    logic [65:0] note_q[$];

    rmc_config_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpio_in(gpio_in), .rssi_level(rssi_level), .rx_active(rx_active), .payload_active(payload_active),
        .restart_pulse(restart_pulse), .iq_cal_done(iq_cal_done), .coding(coding), .modulation(modulation),
        .carrier_sense(carrier_sense), .iq_cal_busy(iq_cal_busy), .rx_term_error(rx_term_error),
        .rx_term_restart(rx_term_restart), .recal_request(recal_request));

    initial
    begin
        forever #20 pclk = ~pclk;
    end
    // ****************************************
    // checking and reporting
    // ****************************************
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // pulse counters use nba so waiting loops see them one edge later, never racing
    always @(posedge pclk)
    begin
        if (rx_term_error === 1'b1) err_cnt <= err_cnt + 1;
        if (rx_term_restart === 1'b1) rst_cnt <= rst_cnt + 1;
        if (recal_request === 1'b1) recal_cnt <= recal_cnt + 1;
        if (psel && penable && pready === 1'b1)
        begin
            if (note_q.size() == 0)
                check({pslverr, prdata}, 33'h1_dead_beef);
            else
            begin
                logic [65:0] n;
                n = note_q.pop_front();
                check({pslverr, prdata} & n[65:33], n[32:0]);
            end
        end
    end
    // ****************************************
    // bus and wait tasks
    // ****************************************
    task automatic apb_xfer(input logic [5:0] idx, input logic wr, input logic [31:0] wd, input logic [32:0] exp);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        note_q.push_back(wr ? {33'h1_0000_0000, exp & 33'h1_0000_0000} : {33'h1_ffff_ffff, exp});
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (n >= 20)
        begin
            check(1'b0, 1'b1);
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb_xfer(idx, 1'b1, {24'h00_0000, d}, 33'h0_0000_0000);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [32:0] exp);
        apb_xfer(idx, 1'b0, 32'h0000_0000, exp);
    endtask : rd

    function automatic bit hit(input int w, input int b);
        return w == 0 ? err_cnt != b : w == 1 ? rst_cnt != b : iq_cal_busy === 1'b0;
    endfunction : hit

    task automatic wait_on(input int w, input int lim, output int dt);
        int b;
        b = (w == 0) ? err_cnt : rst_cnt;
        dt = 0;
        while (!hit(w, b) && dt < lim)
        begin
            @(posedge pclk);
            dt++;
        end
        if (dt >= lim)
        begin
            check(1'b0, 1'b1);
            complete_run();
        end
    endtask : wait_on
    // ****************************************
    // scenarios
    // ****************************************
    logic [5:0] idx_t[7] = '{IDX_IQ_RSSI_BW, IDX_BIT_CODING, IDX_MODULATION, IDX_CS_THRESH, IDX_RX_TERM_INT,
        IDX_RX_TERM_CAL, IDX_RX_TERM_ACT};
    logic [7:0] msk_t[7] = '{8'hbf, 8'hff, 8'hff, MASK_CS, 8'hff, MASK_CAL, MASK_ACT};
    int rc_code[4] = '{0, 1, 2, 7};
    int rc_n[4] = '{3, 8, 8, 8};
    int rc_exp[4] = '{3, 2, 1, 0};

    initial
    begin
        logic [7:0] r, a, b, c;
        int dt, e0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (idx_t[i]) rd(idx_t[i], 33'h0_0000_0000);
        foreach (idx_t[i])
        begin
            r = 8'($random(seed));
            wr(idx_t[i], (i == 0) ? (r & 8'hbf) : r);
            rd(idx_t[i], {25'h0, r & msk_t[i]});
        end
        foreach (idx_t[i])
        begin
            r = 8'($random(seed)) & msk_t[i];
            wr(idx_t[i], r);
            rd(idx_t[i], {25'h0, r});
        end
        rd(6'h2b, 33'h1_0000_0000);
        apb_xfer(6'h3f, 1'b1, 32'h0000_00ff, 33'h1_0000_0000);
        for (int k = 0; k < 8; k++)
        begin
            a = 8'($random(seed)) & 8'hbf;
            b = 8'($random(seed));
            c = {5'($random(seed)), 3'(k)};
            gpio_in <= 4'($random(seed));
            wr(IDX_IQ_RSSI_BW, a);
            wr(IDX_BIT_CODING, b);
            wr(IDX_MODULATION, c);
            repeat (5) @(posedge pclk);
            check(33'(coding), {18'h0, a[7], a[5:0], b});
            check(33'(modulation[6:2]), 33'(c[7:3]));
            check(33'(modulation.source_a_active), 33'(k >= 2));
            if (k >= 2) check(33'(modulation.source_a_level), 33'(k >= 4 ? gpio_in[k-4] : k[0]));
        end
        wr(IDX_CS_THRESH, 8'h05);
        for (int v = 4; v < 8; v++)
        begin
            rssi_level <= 4'(v);
            repeat (6) @(posedge pclk);
            check(33'(carrier_sense), 33'(v > 5));
        end
        wr(IDX_IQ_RSSI_BW, 8'h40);
        rd(IDX_IQ_RSSI_BW, 33'h0_0000_0040);
        check(33'(iq_cal_busy), 33'h1);
        wait_on(2, 1100, dt);
        check(33'(dt > 990 && dt < 1000), 33'h1);
        rd(IDX_IQ_RSSI_BW, 33'h0_0000_0000);
        wr(IDX_IQ_RSSI_BW, 8'h40);
        wr(IDX_IQ_RSSI_BW, 8'h00);
        repeat (3) @(posedge pclk);
        check(33'(iq_cal_busy), 33'h0);
        wr(IDX_IQ_RSSI_BW, 8'hc0);
        iq_cal_done <= 1'b1;
        @(posedge pclk);
        iq_cal_done <= 1'b0;
        repeat (3) @(posedge pclk);
        check(33'(iq_cal_busy), 33'h0);
        wr(IDX_RX_TERM_INT, 8'h00);
        wr(IDX_RX_TERM_CAL, 8'h47);
        wr(IDX_RX_TERM_ACT, 8'h00);
        e0 = rst_cnt;
        rx_active <= 1'b1;
        wait_on(0, 2200, dt);
        check(33'(dt >= 2046 && dt <= 2060), 33'h1);
        rx_active <= 1'b0;
        wr(IDX_RX_TERM_ACT, 8'h80);
        wr(IDX_RX_TERM_INT, 8'h01);
        repeat (4) @(posedge pclk);
        rx_active <= 1'b1;
        wait_on(1, 4300, dt);
        check(33'(dt >= 4094 && dt <= 4108), 33'h1);
        rx_active <= 1'b0;
        wr(IDX_RX_TERM_CAL, 8'hc7);
        payload_active <= 1'b1;
        repeat (4) @(posedge pclk);
        e0 = rst_cnt + err_cnt;
        rx_active <= 1'b1;
        repeat (4300) @(posedge pclk);
        rd(IDX_STATUS, 33'h0_0000_000a);
        repeat (100) @(posedge pclk);
        check(33'(rst_cnt + err_cnt), 33'(e0));
        payload_active <= 1'b0;
        wait_on(1, 12, dt);
        rx_active <= 1'b0;
        foreach (rc_code[i])
        begin
            wr(IDX_RX_TERM_CAL, 8'(rc_code[i]));
            e0 = recal_cnt;
            repeat (rc_n[i])
            begin
                restart_pulse <= 1'b1;
                repeat (4) @(posedge pclk);
                restart_pulse <= 1'b0;
                repeat (4) @(posedge pclk);
            end
            repeat (4) @(posedge pclk);
            check(33'(recal_cnt - e0), 33'(rc_exp[i]));
        end
        repeat (4) @(posedge pclk);
        complete_run();
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        fails++;
        complete_run();
    end
endmodule : rmc_config_bank_bench
`default_nettype wire
